// ### verilog/fb_pkg.sv
`default_nettype none
package fb_pkg;

	// ==========================================================
	// Widths of the feedback word and the two processing paths.
	localparam int WORD_W      = 16;
	localparam int OFFSET_W    = 10;
	localparam int FWD_SHIFT_W = 4;
	localparam int FWD_MASK_W  = 16;
	localparam int DEC_SHIFT_W = 3;
	localparam int DEC_MASK_W  = 8;
	localparam int ADDR_W      = 8;

	// ==========================================================
	// Register byte offsets.
	localparam logic [ADDR_W-1:0] FWD_CFG_OFS  = 8'h00;
	localparam logic [ADDR_W-1:0] DEC_CFG_OFS  = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h08;
	localparam logic [ADDR_W-1:0] RAW_WORD_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] FWD_WORD_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] DEC_WORD_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] RESULT_OFS   = 8'h18;

	// ==========================================================
	// Field positions inside a path configuration word.
	localparam int SHIFT_LSB  = 0;
	localparam int OFFSET_LSB = 4;
	localparam int MASK_LSB   = 16;

	// ==========================================================
	// Reset values of the path parameters.
	localparam logic [FWD_SHIFT_W-1:0] FWD_SHIFT_RST = 4'h0;
	localparam logic [FWD_MASK_W-1:0]  FWD_MASK_RST  = 16'hFFFF;
	localparam logic [DEC_SHIFT_W-1:0] DEC_SHIFT_RST = 3'h0;
	localparam logic [DEC_MASK_W-1:0]  DEC_MASK_RST  = 8'hFF;
	localparam logic [OFFSET_W-1:0]    OFFSET_RST    = 10'h000;

	// ==========================================================
	// Bus answers and the source tag of a link message.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic       TAG_FWD     = 1'b0;

	// Feedback source selected by the first operand of an instruction.
	typedef enum logic [1:0] {
		SRC_RAW,
		SRC_FWD,
		SRC_DEC
	} src_e;

endpackage : fb_pkg
`default_nettype wire

// ### verilog/fb_reduce.sv
`timescale 1ns/1ns
`default_nettype none
module fb_reduce #(
	parameter int SHIFT_W = 4,
	parameter int MASK_W  = 16
) (
	input  wire logic [fb_pkg::WORD_W-1:0]   word,
	input  wire logic [SHIFT_W-1:0]          shift,
	input  wire logic [MASK_W-1:0]           mask,
	input  wire logic [fb_pkg::OFFSET_W-1:0] offset,
	input  wire logic                        configured,
	output logic      [fb_pkg::WORD_W-1:0]   result
);
	import fb_pkg::*;

	logic [WORD_W-1:0] shifted;
	logic [WORD_W-1:0] trimmed;

	// One independent chain: shift right, trim by the mask, add offset.
	always_comb begin
		shifted = word >> shift;
		trimmed = shifted & WORD_W'(mask);
		if (configured) begin
			result = trimmed + WORD_W'(offset);
		end else begin
			result = word;
		end
	end

endmodule : fb_reduce
`default_nettype wire

// ### verilog/feedback_word_processing.sv
`timescale 1ns/1ns
`default_nettype none
module feedback_word_processing (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [fb_pkg::ADDR_W-1:0]     awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [fb_pkg::ADDR_W-1:0]     araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	input  wire logic                          link_toggle,
	input  wire logic                          link_tag,
	input  wire logic [fb_pkg::WORD_W-1:0]     link_word,
	input  wire logic                          fb_req,
	input  wire logic                          fb_play,
	input  wire fb_pkg::src_e                  fb_src,
	input  wire logic                          cfg_we,
	input  wire fb_pkg::src_e                  cfg_path,
	input  wire logic [fb_pkg::FWD_SHIFT_W-1:0] cfg_shift,
	input  wire logic [fb_pkg::FWD_MASK_W-1:0] cfg_mask,
	input  wire logic [fb_pkg::OFFSET_W-1:0]   cfg_offset,
	output logic                               play_valid,
	output logic [fb_pkg::WORD_W-1:0]          play_index,
	output logic                               read_valid,
	output logic [fb_pkg::WORD_W-1:0]          read_value
);
	import fb_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic                   tgl_s1;
		logic                   tgl_s2;
		logic                   tgl_s3;
		logic                   tag_s1;
		logic                   tag_s2;
		logic [WORD_W-1:0]      word_s1;
		logic [WORD_W-1:0]      word_s2;
		logic [WORD_W-1:0]      raw_word;
		logic [WORD_W-1:0]      fwd_word;
		logic [WORD_W-1:0]      dec_word;
		logic [FWD_SHIFT_W-1:0] fwd_shift;
		logic [FWD_MASK_W-1:0]  fwd_mask;
		logic [OFFSET_W-1:0]    fwd_off;
		logic                   fwd_cfgd;
		logic [DEC_SHIFT_W-1:0] dec_shift;
		logic [DEC_MASK_W-1:0]  dec_mask;
		logic [OFFSET_W-1:0]    dec_off;
		logic                   dec_cfgd;
		logic                   play_valid;
		logic [WORD_W-1:0]      play_index;
		logic                   stage_valid;
		logic [WORD_W-1:0]      stage_value;
		logic                   read_valid;
		logic [WORD_W-1:0]      read_value;
		logic [WORD_W-1:0]      last_result;
		logic                   aw_held;
		logic [ADDR_W-1:0]      awaddr;
		logic                   w_held;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [WORD_W-1:0] fwd_res;
	logic [WORD_W-1:0] dec_res;
	logic [WORD_W-1:0] sel_res;
	logic              msg_new;

	// ==========================================================
	// Helpers
	// Merges a bus write into an old word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				v[8*i +: 8] = data[8*i +: 8];
			end
		end
		return v;
	endfunction : merge
	// Packs one path's parameters into its register layout.
	function automatic logic [31:0] pack_cfg(input logic [3:0] sh,
		input logic [15:0] mk, input logic [OFFSET_W-1:0] of);
		logic [31:0] v;
		v = '0;
		v[SHIFT_LSB +: 4] = sh;
		v[OFFSET_LSB +: OFFSET_W] = of;
		v[MASK_LSB +: 16] = mk;
		return v;
	endfunction : pack_cfg

	// ==========================================================
	// Processing chains, one per non-raw source.
	fb_reduce #(.SHIFT_W(FWD_SHIFT_W), .MASK_W(FWD_MASK_W)) u_fwd (
		.word       (st_r.fwd_word),
		.shift      (st_r.fwd_shift),
		.mask       (st_r.fwd_mask),
		.offset     (st_r.fwd_off),
		.configured (st_r.fwd_cfgd),
		.result     (fwd_res)
	);
	fb_reduce #(.SHIFT_W(DEC_SHIFT_W), .MASK_W(DEC_MASK_W)) u_dec (
		.word       (st_r.dec_word),
		.shift      (st_r.dec_shift),
		.mask       (st_r.dec_mask),
		.offset     (st_r.dec_off),
		.configured (st_r.dec_cfgd),
		.result     (dec_res)
	);
	// Picks the chain named by the instruction's first operand.
	always_comb begin
		unique case (fb_src)
			SRC_RAW: sel_res = st_r.raw_word;
			SRC_FWD: sel_res = fwd_res;
			SRC_DEC: sel_res = dec_res;
			default: sel_res = st_r.raw_word;
		endcase
	end
	// A changed synchronised toggle announces a new link message.
	assign msg_new = st_r.tgl_s2 != st_r.tgl_s3;
	// ==========================================================
	// Next-state logic
	// Link capture, request answers, parameter updates and bus slave.
	always_comb begin
		logic [ADDR_W-1:0] wa;
		logic [31:0]       nv;
		wa = '0;
		nv = '0;
		st_nxt = st_r;
		// Two-flop synchronisers on every link pin.
		st_nxt.tgl_s1  = link_toggle;
		st_nxt.tgl_s2  = st_r.tgl_s1;
		st_nxt.tgl_s3  = st_r.tgl_s2;
		st_nxt.tag_s1  = link_tag;
		st_nxt.tag_s2  = st_r.tag_s1;
		st_nxt.word_s1 = link_word;
		st_nxt.word_s2 = st_r.word_s1;
		if (msg_new) begin
			st_nxt.raw_word = st_r.word_s2;
			if (st_r.tag_s2 == TAG_FWD) begin
				st_nxt.fwd_word = st_r.word_s2;
			end else begin
				st_nxt.dec_word = st_r.word_s2;
			end
		end
		// Table play answers next cycle; read takes one more stage.
		st_nxt.play_valid  = fb_req && fb_play;
		st_nxt.stage_valid = fb_req && !fb_play;
		st_nxt.read_valid  = st_r.stage_valid;
		if (fb_req && fb_play) begin
			st_nxt.play_index = sel_res;
		end else if (fb_req) begin
			st_nxt.stage_value = sel_res;
		end
		if (st_r.stage_valid) begin
			st_nxt.read_value = st_r.stage_value;
		end
		if (fb_req) begin
			st_nxt.last_result = sel_res;
		end
		// Write address and data, taken in either order.
		if (awvalid && awready) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr  = awaddr;
		end
		if (wvalid && wready) begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata  = wdata;
			st_nxt.wstrb  = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_nxt.aw_held && st_nxt.w_held && !st_r.bvalid) begin
			wa = st_nxt.awaddr;
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = RESP_OKAY;
			if (wa == FWD_CFG_OFS) begin
				nv = merge(pack_cfg(st_r.fwd_shift, st_r.fwd_mask,
					st_r.fwd_off), st_nxt.wdata, st_nxt.wstrb);
				st_nxt.fwd_shift = nv[SHIFT_LSB +: FWD_SHIFT_W];
				st_nxt.fwd_off   = nv[OFFSET_LSB +: OFFSET_W];
				st_nxt.fwd_mask  = nv[MASK_LSB +: FWD_MASK_W];
				st_nxt.fwd_cfgd  = 1'b1;
			end else if (wa == DEC_CFG_OFS) begin
				nv = merge(pack_cfg({1'b0, st_r.dec_shift},
					{8'h00, st_r.dec_mask}, st_r.dec_off),
					st_nxt.wdata, st_nxt.wstrb);
				st_nxt.dec_shift = nv[SHIFT_LSB +: DEC_SHIFT_W];
				st_nxt.dec_off   = nv[OFFSET_LSB +: OFFSET_W];
				st_nxt.dec_mask  = nv[MASK_LSB +: DEC_MASK_W];
				st_nxt.dec_cfgd  = 1'b1;
			end else if (wa != STATUS_OFS && wa != RAW_WORD_OFS &&
				wa != FWD_WORD_OFS && wa != DEC_WORD_OFS &&
				wa != RESULT_OFS) begin
				st_nxt.bresp = RESP_DECERR;
			end
		end
		// Sequencer updates land at once and win over a bus write.
		if (cfg_we && cfg_path == SRC_FWD) begin
			st_nxt.fwd_shift = cfg_shift;
			st_nxt.fwd_mask  = cfg_mask;
			st_nxt.fwd_off   = cfg_offset;
			st_nxt.fwd_cfgd  = 1'b1;
		end else if (cfg_we && cfg_path == SRC_DEC) begin
			st_nxt.dec_shift = cfg_shift[DEC_SHIFT_W-1:0];
			st_nxt.dec_mask  = cfg_mask[DEC_MASK_W-1:0];
			st_nxt.dec_off   = cfg_offset;
			st_nxt.dec_cfgd  = 1'b1;
		end
		// Read channel: answer one cycle after the address is taken.
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = RESP_OKAY;
			st_nxt.rdata  = '0;
			unique case (araddr)
				FWD_CFG_OFS: st_nxt.rdata = pack_cfg(st_r.fwd_shift,
					st_r.fwd_mask, st_r.fwd_off);
				DEC_CFG_OFS: st_nxt.rdata = pack_cfg({1'b0,
					st_r.dec_shift}, {8'h00, st_r.dec_mask},
					st_r.dec_off);
				STATUS_OFS: st_nxt.rdata = {30'h0, st_r.dec_cfgd,
					st_r.fwd_cfgd};
				RAW_WORD_OFS: st_nxt.rdata = {16'h0, st_r.raw_word};
				FWD_WORD_OFS: st_nxt.rdata = {16'h0, st_r.fwd_word};
				DEC_WORD_OFS: st_nxt.rdata = {16'h0, st_r.dec_word};
				RESULT_OFS: st_nxt.rdata = {16'h0, st_r.last_result};
				default: st_nxt.rresp = RESP_DECERR;
			endcase
		end
	end
	// ==========================================================
	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r           <= '0;
			st_r.fwd_shift <= FWD_SHIFT_RST;
			st_r.fwd_mask  <= FWD_MASK_RST;
			st_r.fwd_off   <= OFFSET_RST;
			st_r.dec_shift <= DEC_SHIFT_RST;
			st_r.dec_mask  <= DEC_MASK_RST;
			st_r.dec_off   <= OFFSET_RST;
		end else begin
			st_r <= st_nxt;
		end
	end
	// Handshake outputs and registered data outputs.
	assign awready    = !st_r.aw_held && !st_r.bvalid;
	assign wready     = !st_r.w_held && !st_r.bvalid;
	assign arready    = !st_r.rvalid;
	assign bvalid     = st_r.bvalid;
	assign bresp      = st_r.bresp;
	assign rvalid     = st_r.rvalid;
	assign rdata      = st_r.rdata;
	assign rresp      = st_r.rresp;
	assign play_valid = st_r.play_valid;
	assign play_index = st_r.play_index;
	assign read_valid = st_r.read_valid;
	assign read_value = st_r.read_value;
	// ==========================================================
	// Assertions; a read one cycle earlier answers alongside a play.
	a_play_latency: assert property (@(posedge aclk)
		disable iff (!aresetn) fb_req && fb_play && !st_r.stage_valid
		|=> play_valid && !read_valid)
		else $error("Table play not answered in one cycle.");
	a_read_latency: assert property (@(posedge aclk)
		disable iff (!aresetn) fb_req && !fb_play && !st_r.stage_valid
		|=> !read_valid ##1 read_valid)
		else $error("Feedback read not answered in two cycles.");
	a_raw_word: assert property (@(posedge aclk)
		disable iff (!aresetn) fb_req && fb_play && fb_src == SRC_RAW
		|=> play_index == $past(st_r.raw_word))
		else $error("Raw source altered the word.");
	a_fwd_reduce: assert property (@(posedge aclk)
		disable iff (!aresetn)
		fb_req && fb_play && fb_src == SRC_FWD && st_r.fwd_cfgd
		|=> play_index == $past(((st_r.fwd_word >> st_r.fwd_shift)
		& st_r.fwd_mask) + 16'(st_r.fwd_off)))
		else $error("Forwarded path result is wrong.");
	a_dec_unconf: assert property (@(posedge aclk)
		disable iff (!aresetn)
		fb_req && !fb_play && fb_src == SRC_DEC && !st_r.dec_cfgd
		|=> ##1 read_value == $past(st_r.dec_word, 2))
		else $error("Unconfigured decoder path did not pass through.");
	a_msg_capture: assert property (@(posedge aclk)
		disable iff (!aresetn) msg_new && st_r.tag_s2 == TAG_FWD
		|=> st_r.fwd_word == $past(st_r.word_s2)
		&& st_r.raw_word == $past(st_r.word_s2))
		else $error("Forwarded word not captured.");
	a_cfg_realtime: assert property (@(posedge aclk)
		disable iff (!aresetn) cfg_we && cfg_path == SRC_FWD
		|=> st_r.fwd_cfgd && st_r.fwd_off == $past(cfg_offset)
		&& st_r.fwd_mask == $past(cfg_mask))
		else $error("Sequencer update not applied next cycle.");
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("Write response dropped before acceptance.");
endmodule : feedback_word_processing
`default_nettype wire

// ### dv/fb_link_src.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Central controller model: sends one 16-bit word per toggle change.
module fb_link_src (
	input  wire logic        aclk,
	output logic             link_toggle,
	output logic             link_tag,
	output logic [15:0]      link_word
);
	import fb_pkg::*;

	// Idle levels at time zero.
	initial begin
		link_toggle = 1'b0;
		link_tag    = 1'b0;
		link_word   = 16'h0000;
	end

	// Word and tag set up two cycles early, held five cycles after the
	// toggle, then scrambled so a late capture cannot pass by accident.
	task automatic send(input logic tag, input logic [15:0] word);
		@(posedge aclk);
		link_tag  <= tag;
		link_word <= word;
		repeat (2) @(posedge aclk);
		link_toggle <= ~link_toggle;
		repeat (5) @(posedge aclk);
		link_tag  <= ~tag;
		link_word <= ~word;
	endtask : send
endmodule : fb_link_src
`default_nettype wire

// ### dv/feedback_word_processing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module feedback_word_processing_tb;
	import fb_pkg::*;

	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        link_toggle, link_tag, fb_req, fb_play, cfg_we;
	logic [15:0] link_word, cfg_mask, play_index, read_value;
	logic [3:0]  cfg_shift;
	logic [9:0]  cfg_offset;
	logic        play_valid, read_valid;
	src_e        fb_src, cfg_path;
	int          miscompares, check_count;

	feedback_word_processing u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link_toggle(link_toggle), .link_tag(link_tag),
		.link_word(link_word), .fb_req(fb_req), .fb_play(fb_play),
		.fb_src(fb_src), .cfg_we(cfg_we), .cfg_path(cfg_path),
		.cfg_shift(cfg_shift), .cfg_mask(cfg_mask),
		.cfg_offset(cfg_offset), .play_valid(play_valid),
		.play_index(play_index), .read_valid(read_valid),
		.read_value(read_value));

	fb_link_src u_src (.aclk(aclk), .link_toggle(link_toggle),
		.link_tag(link_tag), .link_word(link_word));

	// ==========================================================
	// Verdict and comparison helpers.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask : check

	// Expected reduction, worked out independently of the design.
	function automatic logic [15:0] calc(input logic [15:0] w, input int sh,
		input logic [15:0] m, input logic [15:0] of);
		return ((w >> sh) & m) + of;
	endfunction : calc

	// ==========================================================
	// AXI4-Lite master cycles; each waits for the answer under a bound.
	// Handshakes are judged on values settled before the edge, so a
	// ready or valid that the edge itself changes is never misread.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int   i;
		logic aw_hs, w_hs, done;
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= 4'hF;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs  = wvalid && wready;
			done  = bvalid === 1'b1;
			resp  = bresp;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (done) break;
		end
		bready <= 1'b0;
		if (i == 50) begin miscompares++; end_sim(); end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int   i;
		logic ar_hs, done;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			done  = rvalid === 1'b1;
			got   = rdata;
			resp  = rresp;
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'b0;
			if (done) break;
		end
		rready <= 1'b0;
		if (i == 50) begin miscompares++; end_sim(); end
	endtask : axi_rd

	// Sequencer request; play answers one cycle after, read two.
	task automatic seq_req(input logic play, input src_e src,
		input logic [15:0] exp);
		@(posedge aclk);
		fb_req <= 1'b1; fb_play <= play; fb_src <= src;
		@(posedge aclk);
		fb_req <= 1'b0;
		#1;
		if (play) begin
			check(play_valid, 1'b1, "play valid");
			check(play_index, exp, "play index");
		end else begin
			check(read_valid, 1'b0, "read early");
			@(posedge aclk); #1;
			check(read_valid, 1'b1, "read valid");
			check(read_value, exp, "read value");
		end
	endtask : seq_req

	task automatic seq_cfg(input src_e p, input logic [3:0] sh,
		input logic [15:0] m, input logic [9:0] of);
		@(posedge aclk);
		cfg_we <= 1'b1; cfg_path <= p;
		cfg_shift <= sh; cfg_mask <= m; cfg_offset <= of;
		@(posedge aclk);
		cfg_we <= 1'b0;
	endtask : seq_cfg

	// ==========================================================
	// Scenarios.
	task automatic t_passthru();
		axi_rd(FWD_CFG_OFS); check(got, 32'hFFFF0000, "fwd cfg rst");
		axi_rd(DEC_CFG_OFS); check(got, 32'h00FF0000, "dec cfg rst");
		axi_rd(STATUS_OFS);  check(got, 32'h0, "status rst");
		u_src.send(TAG_FWD, 16'hA5C3);
		axi_rd(RAW_WORD_OFS); check(got, 32'hA5C3, "raw word");
		axi_rd(FWD_WORD_OFS); check(got, 32'hA5C3, "fwd word");
		seq_req(1'b1, SRC_FWD, 16'hA5C3);
		seq_req(1'b0, SRC_RAW, 16'hA5C3);
		u_src.send(~TAG_FWD, 16'h5A3C);
		seq_req(1'b0, SRC_DEC, 16'h5A3C);
		seq_req(1'b0, SRC_FWD, 16'hA5C3);
		axi_rd(DEC_WORD_OFS); check(got, 32'h5A3C, "dec word");
		$display("done t_passthru");
	endtask : t_passthru

	task automatic t_limits();
		axi_wr(FWD_CFG_OFS, 32'hFFFF3FFF); check(resp, RESP_OKAY, "wr");
		axi_wr(DEC_CFG_OFS, 32'h00FF3FF7); check(resp, RESP_OKAY, "wr");
		axi_rd(STATUS_OFS); check(got, 32'h3, "status cfg");
		seq_req(1'b1, SRC_FWD, calc(16'hA5C3, 15, 16'hFFFF, 16'h3FF));
		seq_req(1'b1, SRC_DEC, calc(16'h5A3C, 7, 16'h00FF, 16'h3FF));
		seq_req(1'b0, SRC_RAW, 16'h5A3C);
		axi_rd(RESULT_OFS); check(got, 32'h5A3C, "last result");
		$display("done t_limits");
	endtask : t_limits

	task automatic t_realtime();
		seq_cfg(SRC_FWD, 4'h4, 16'h000F, 10'h010);
		seq_req(1'b1, SRC_FWD, calc(16'hA5C3, 4, 16'h000F, 16'h010));
		seq_cfg(SRC_DEC, 4'hB, 16'hFF0F, 10'h002);
		seq_req(1'b0, SRC_DEC, calc(16'h5A3C, 3, 16'h000F, 16'h002));
		seq_cfg(SRC_RAW, 4'h0, 16'h0000, 10'h000);
		seq_req(1'b1, SRC_FWD, calc(16'hA5C3, 4, 16'h000F, 16'h010));
		u_src.send(TAG_FWD, 16'h0F70);
		seq_req(1'b1, SRC_FWD, calc(16'h0F70, 4, 16'h000F, 16'h010));
		seq_req(1'b1, SRC_DEC, calc(16'h5A3C, 3, 16'h000F, 16'h002));
		$display("done t_realtime");
	endtask : t_realtime

	task automatic t_bus_err();
		axi_wr(8'h40, 32'h12345678); check(resp, RESP_DECERR, "wr decerr");
		axi_rd(8'h40); check(resp, RESP_DECERR, "rd decerr");
		check(got, 32'h0, "rd decerr data");
		axi_wr(RAW_WORD_OFS, 32'hFFFF); check(resp, RESP_OKAY, "ro write");
		axi_rd(RAW_WORD_OFS); check(got, 32'h0F70, "ro kept");
		$display("done t_bus_err");
	endtask : t_bus_err

	// ==========================================================
	// Clock, reset and the main sequence.
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	initial begin
		miscompares = 0; check_count = 0;
		aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
		wdata = 32'h0; wstrb = 4'h0; fb_req = 1'b0; fb_play = 1'b0;
		fb_src = SRC_RAW; cfg_we = 1'b0; cfg_path = SRC_RAW;
		cfg_shift = 4'h0; cfg_mask = 16'h0000; cfg_offset = 10'h000;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_passthru();
		t_limits();
		t_realtime();
		t_bus_err();
		end_sim();
	end
endmodule : feedback_word_processing_tb
`default_nettype wire
